// File: sbmu_regs.vh
// Constants for the system-register bit manipulation unit
`ifndef SBMU_REGS_VH
`define SBMU_REGS_VH

// Wishbone register byte offsets
`define SBMU_ADDR_CTRL      4'h0
`define SBMU_ADDR_IMM       4'h4
`define SBMU_ADDR_XREG      4'h8
`define SBMU_ADDR_YREG      4'hC
`define SBMU_ADDR_STATUS    5'h10
`define SBMU_ADDR_OTHER     5'h14
`define SBMU_ADDR_W         5

// Control register fields
`define SBMU_CTRL_OP_LSB    0
`define SBMU_CTRL_OP_MSB    2
`define SBMU_CTRL_SIMD      3
`define SBMU_CTRL_COMP      4
`define SBMU_CTRL_GO        8

// Status register fields
`define SBMU_STAT_FLAGX     0
`define SBMU_STAT_FLAGY     1
`define SBMU_STAT_YDONE     2
`define SBMU_STAT_RSVD      3

// Operation codes
`define SBMU_OP_SET         3'h0
`define SBMU_OP_CLR         3'h1
`define SBMU_OP_TGL         3'h2
`define SBMU_OP_TST         3'h4
`define SBMU_OP_CMP         3'h5

`define SBMU_ZERO32         32'h00000000
`define SBMU_ZERO3          3'h0

`endif

// File: sbmu_pe_op.v
// One processing element's bit manipulation datapath
module sbmu_pe_op #(
  parameter WIDTH = 32
) (
  input  wire [2:0]       op,
  input  wire [WIDTH-1:0] imm,
  input  wire [WIDTH-1:0] regIn,
  output reg  [WIDTH-1:0] regOut,
  output reg              writeEn,
  output reg              flagEn,
  output reg              flag
);
`include "sbmu_regs.vh"

  always @* begin
    regOut  = regIn;
    writeEn = 1'b0;
    flagEn  = 1'b0;
    flag    = 1'b0;
    case (op)
      `SBMU_OP_SET: begin
        regOut  = regIn | imm;
        writeEn = 1'b1;
      end
      `SBMU_OP_CLR: begin
        regOut  = regIn & ~imm;
        writeEn = 1'b1;
      end
      `SBMU_OP_TGL: begin
        regOut  = regIn ^ imm;
        writeEn = 1'b1;
      end
      `SBMU_OP_TST: begin
        flagEn = 1'b1;
        flag   = ((regIn & imm) == imm);
      end
      `SBMU_OP_CMP: begin
        flagEn = 1'b1;
        flag   = (regIn == imm);
      end
      default: begin
        // Reserved codes leave register and flag alone
        writeEn = 1'b0;
      end
    endcase
  end

endmodule // sbmu_pe_op

// File: sbmu_unit.v
// Top of the system-register bit manipulation unit with Wishbone slave
// Notes on behaviour
// - Set: mask ones force register bits high
// - Clear: mask ones force register bits low
// - Toggle: mask ones invert register bits
// - Test: flag set when all mask bits set
// - Compare: flag set when register equals immediate
// - Immediate is mask, except compare uses value
// - SIMD runs both elements, Y on complement
// - No complement: SIMD behaves like SISD
// - SIMD test/compare evaluated per element
// - Each element updates its own flag
// - SISD operates on element X only
//
// Software loads the immediate and both system register copies,
// then writes the control word with the go bit to run one instruction.
// The operation completes in the same write cycle.
module sbmu_unit #(
  parameter WIDTH = 32
) (
  input  wire             clock,
  input  wire             rst_n,
  input  wire             wb_cyc_i,
  input  wire             wb_stb_i,
  input  wire             wb_we_i,
  input  wire [4:0]       wb_adr_i,
  input  wire [3:0]       wb_sel_i,
  input  wire [31:0]      wb_dat_i,
  output reg  [31:0]      wb_dat_o,
  output reg              wb_ack_o,
  output wire             bitTestFlagX,
  output wire             bitTestFlagY
);
`include "sbmu_regs.vh"

  // ==========================================================
  // Reset synchroniser
  reg rstMeta;
  reg rstSync;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // ==========================================================
  // State
  reg [2:0]       opCode;
  reg             simdMode;
  reg             hasComplement;
  reg [WIDTH-1:0] immValue;
  reg [WIDTH-1:0] sysRegX;
  reg [WIDTH-1:0] sysRegY;
  reg             flagX;
  reg             flagY;
  reg             yDone;

  assign bitTestFlagX = flagX;
  assign bitTestFlagY = flagY;

  // Byte-lane merge used for every writable word
  function [31:0] laneMerge;
    input [31:0] oldVal;
    input [31:0] newVal;
    input [3:0]  sel;
    integer i;
    begin
      laneMerge = oldVal;
      for (i = 0; i < 4; i = i + 1) begin
        if (sel[i]) begin
          laneMerge[i*8 +: 8] = newVal[i*8 +: 8];
        end
      end
    end
  endfunction

  // ==========================================================
  // Bus decode
  wire busReq  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire busWr   = busReq & wb_we_i;
  wire hitCtrl = (wb_adr_i == {1'b0, `SBMU_ADDR_CTRL});
  wire hitImm  = (wb_adr_i == {1'b0, `SBMU_ADDR_IMM});
  wire hitX    = (wb_adr_i == {1'b0, `SBMU_ADDR_XREG});
  wire hitY    = (wb_adr_i == {1'b0, `SBMU_ADDR_YREG});
  wire hitStat = (wb_adr_i == `SBMU_ADDR_STATUS);

  wire [31:0] ctrlWord = laneMerge(
    {23'h000000, 1'b0, 3'h0, hasComplement, simdMode, opCode},
    wb_dat_i, wb_sel_i);
  wire        goPulse  = busWr & hitCtrl & ctrlWord[`SBMU_CTRL_GO];

  // The go write supplies the op and mode for this very instruction
  wire [2:0] runOp   = ctrlWord[`SBMU_CTRL_OP_MSB:`SBMU_CTRL_OP_LSB];
  wire       runSimd = ctrlWord[`SBMU_CTRL_SIMD];
  wire       runComp = ctrlWord[`SBMU_CTRL_COMP];
  // Y element joins only in SIMD with a complementary register
  wire       runY    = runSimd & runComp;

  // ==========================================================
  // Per-element datapaths
  wire [WIDTH-1:0] resX;
  wire [WIDTH-1:0] resY;
  wire             wrX;
  wire             wrY;
  wire             fEnX;
  wire             fEnY;
  wire             fX;
  wire             fY;

  sbmu_pe_op #(.WIDTH(WIDTH)) uPeX (
    .op      (runOp),
    .imm     (immValue),
    .regIn   (sysRegX),
    .regOut  (resX),
    .writeEn (wrX),
    .flagEn  (fEnX),
    .flag    (fX)
  );

  // Y reads its own copy, so its test result is independent
  sbmu_pe_op #(.WIDTH(WIDTH)) uPeY (
    .op      (runOp),
    .imm     (immValue),
    .regIn   (sysRegY),
    .regOut  (resY),
    .writeEn (wrY),
    .flagEn  (fEnY),
    .flag    (fY)
  );

  // ==========================================================
  // Registers
  always @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      opCode        <= `SBMU_ZERO3;
      simdMode      <= 1'b0;
      hasComplement <= 1'b0;
      immValue      <= `SBMU_ZERO32;
      sysRegX       <= `SBMU_ZERO32;
      sysRegY       <= `SBMU_ZERO32;
      flagX         <= 1'b0;
      flagY         <= 1'b0;
      yDone         <= 1'b0;
    end else begin
      if (busWr & hitCtrl) begin
        opCode        <= runOp;
        simdMode      <= runSimd;
        hasComplement <= runComp;
      end
      if (busWr & hitImm) begin
        immValue <= laneMerge(immValue, wb_dat_i, wb_sel_i);
      end
      // Instruction results take priority over a direct load
      if (goPulse & wrX) begin
        sysRegX <= resX;
      end else if (busWr & hitX) begin
        sysRegX <= laneMerge(sysRegX, wb_dat_i, wb_sel_i);
      end
      if (goPulse & runY & wrY) begin
        sysRegY <= resY;
      end else if (busWr & hitY) begin
        sysRegY <= laneMerge(sysRegY, wb_dat_i, wb_sel_i);
      end
      if (goPulse & fEnX) begin
        flagX <= fX;
      end
      if (goPulse & runY & fEnY) begin
        flagY <= fY;
      end
      if (goPulse) begin
        yDone <= runY & (wrY | fEnY);
      end
    end
  end

  // ==========================================================
  // Bus answer: one registered ack the cycle after the request, unmapped reads return zero
  always @(posedge clock or negedge rstSync) begin
    if (!rstSync) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `SBMU_ZERO32;
    end else begin
      wb_ack_o <= busReq;
      if (busReq & ~wb_we_i) begin
        if (hitCtrl) begin
          wb_dat_o <= {27'h0000000, hasComplement, simdMode, opCode};
        end else if (hitImm) begin
          wb_dat_o <= immValue;
        end else if (hitX) begin
          wb_dat_o <= sysRegX;
        end else if (hitY) begin
          wb_dat_o <= sysRegY;
        end else if (hitStat) begin
          wb_dat_o <= {29'h00000000, yDone, flagY, flagX};
        end else begin
          wb_dat_o <= `SBMU_ZERO32;
        end
      end
    end
  end

endmodule // sbmu_unit

// File: sbmu_properties.sv
// Port-level checks for the bit manipulation unit
module sbmu_properties (
  input wire        clock,
  input wire        rst_n,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [4:0]  wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_ack_o,
  input wire        bitTestFlagX,
  input wire        bitTestFlagY
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       go;
  logic [2:0] op;
  logic [1:0] fl;
  assign op = wb_dat_i[2:0];
  assign fl = {bitTestFlagY, bitTestFlagX};
  // Instruction launch: control write with go bit, both low lanes on
  assign go = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o &&
              wb_adr_i == 5'h00 && (&wb_sel_i[1:0]) && wb_dat_i[8];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack_o)
    |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_flag_cause: assert property (!$stable(fl) |-> $past(go))
    else $error("flag moved without instruction");
  a_manip_flag_keep: assert property (go && op <= 3'h2
    |=> $stable(fl)) else $error("set/clr/tgl moved flag");
  a_rsvd_flag_keep: assert property (
    go && (op == 3'h3 || op >= 3'h6)
    |=> $stable(fl)) else $error("reserved op moved flag");
  a_sisd_y_keep: assert property (go && !wb_dat_i[3]
    |=> $stable(bitTestFlagY)) else $error("SISD touched Y");
  a_nocomp_y_keep: assert property (go && !wb_dat_i[4]
    |=> $stable(bitTestFlagY)) else $error("no complement touched Y");
endmodule // sbmu_properties

bind sbmu_unit sbmu_properties i_props (.clock(clock), .rst_n(rst_n),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .bitTestFlagX(bitTestFlagX),
  .bitTestFlagY(bitTestFlagY));

// File: sbmu_wb_host.sv
// Wishbone master standing in for the instruction decoder
module sbmu_wb_host (
  input  wire         clock,
  input  wire         ack,
  input  wire  [31:0] rdat,
  output logic        cyc,
  output logic        stb,
  output logic        we,
  output logic [4:0]  adr,
  output logic [3:0]  sel,
  output logic [31:0] wdat
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 5'h00;
    sel = 4'h0;
    wdat = 32'h00000000;
  end
  // Entered right after a rising edge; hangs are left to the watchdog
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    do @(posedge clock); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    // Released data must not look like held data
    wdat <= ~d;
    @(posedge clock);
  endtask
endmodule // sbmu_wb_host

// File: tb_top.sv
// Self-checking bench for the bit manipulation unit
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [4:0]  ctl;
    logic [31:0] imm, x, y, ex, ey;
    logic [1:0]  fl;
  } sbmu_row_t;
  logic        clock = 1'b0;
  logic        rst_n, cyc, stb, we, ack, flagX, flagY;
  logic [4:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  int          n_errors = 0;
  int          n_compared = 0;
  // ctl = {complement, simd, op}; fl = {flagY, flagX}
  sbmu_row_t rows [11] = '{
    '{5'h04, 32'h2000, 32'hF000, 32'h0, 32'hF000, 32'h0, 2'b01},
    '{5'h18, 32'h70, 32'h1, 32'h80000000, 32'h71, 32'h80000070, 2'b01},
    '{5'h19, 32'hFF00, 32'h12345678, 32'hFFFFFFFF, 32'h12340078,
      32'hFFFF00FF, 2'b01},
    '{5'h0A, 32'h0F0F0F0F, 32'h00FF00FF, 32'h11111111, 32'h0FF00FF0,
      32'h11111111, 2'b01},
    '{5'h1C, 32'h3, 32'h1, 32'h7, 32'h1, 32'h7, 2'b10},
    '{5'h1D, 32'hCAFE0001, 32'hCAFE0001, 32'hFFFFFFFF, 32'hCAFE0001,
      32'hFFFFFFFF, 2'b01},
    '{5'h1B, 32'hFFFFFFFF, 32'h0, 32'h0, 32'h0, 32'h0, 2'b01},
    '{5'h1E, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 2'b01},
    '{5'h1F, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 2'b01},
    '{5'h05, 32'h0, 32'h1, 32'h0, 32'h1, 32'h0, 2'b00},
    '{5'h1C, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 2'b11}};

  always #50 clock = ~clock;

  sbmu_unit i_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .bitTestFlagX(flagX), .bitTestFlagY(flagY));
  sbmu_wb_host i_host (.clock(clock), .ack(ack), .rdat(rdat),
    .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(wdat));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    foreach (rows[i]) begin
      i_host.xfer(1'b1, 5'h04, rows[i].imm, 4'hF, q);
      i_host.xfer(1'b1, 5'h08, rows[i].x, 4'hF, q);
      i_host.xfer(1'b1, 5'h0C, rows[i].y, 4'hF, q);
      i_host.xfer(1'b1, 5'h00, {23'h0, 1'b1, 3'h0, rows[i].ctl}, 4'hF, q);
      i_host.xfer(1'b0, 5'h08, 32'h0, 4'hF, q);
      chk(q, rows[i].ex);
      i_host.xfer(1'b0, 5'h0C, 32'h0, 4'hF, q);
      chk(q, rows[i].ey);
      chk({30'h0, flagY, flagX}, {30'h0, rows[i].fl});
    end
    i_host.xfer(1'b0, 5'h10, 32'h0, 4'hF, q);
    chk(q, 32'h7);
    // Control word reads back without the go bit
    i_host.xfer(1'b0, 5'h00, 32'h0, 4'hF, q);
    chk(q, 32'h1C);
    i_host.xfer(1'b0, 5'h18, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    // Write with no lanes enabled must leave the register alone
    i_host.xfer(1'b1, 5'h08, 32'hFFFFFFFF, 4'h0, q);
    i_host.xfer(1'b0, 5'h08, 32'h0, 4'hF, q);
    chk(q, 32'h0);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    chk({30'h0, flagY, flagX}, 32'h0);
    end_sim;
  end

  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    end_sim;
  end
endmodule // tb_top
